// ===== dsp_pkg.sv
// Purpose: Shared constants and types of the descriptor prefetcher.
// Assumes: Single clock, standard 256-bit descriptors, no extended features.
// Notes: CSR offsets are word indexes on the 3-bit CSR address.
`default_nettype none

package dsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 256;
  localparam int BE_W = DATA_W / 8;
  localparam int BURST_W = 1;
  localparam int CSR_AW = 3;
  localparam int CSR_DW = 32;
  localparam int POLL_W = 16;
  localparam int SRC_W = 128;

  ////////////////////////////////////////////////////////////////////////////
  // CSR word offsets
  localparam logic [CSR_AW-1:0] OFS_NEXT_PTR = 3'h0;
  localparam logic [CSR_AW-1:0] OFS_CONTROL = 3'h1;
  localparam logic [CSR_AW-1:0] OFS_POLL = 3'h2;
  localparam logic [CSR_AW-1:0] OFS_STATUS = 3'h3;

  // Control bit positions
  localparam int CTL_RUN = 0;
  localparam int CTL_POLL_EN = 1;
  localparam int CTL_SRST = 2;
  localparam int CTL_GIE = 3;
  // Status bit position
  localparam int STS_IRQ = 0;

  // Reset values and the fixed burst count
  localparam logic [ADDR_W-1:0] NEXT_PTR_RST = 32'h0000_0000;
  localparam logic [POLL_W-1:0] POLL_RST = 16'h0000;
  localparam logic [BURST_W-1:0] BURST_ONE = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor layout in one memory word
  localparam int D_RD_ADDR = 0;
  localparam int D_WR_ADDR = 32;
  localparam int D_LEN = 64;
  localparam int D_NEXT = 96;
  localparam int D_CTRL = 224;
  localparam int D_OWN = 254;

  // Word handed to the dispatcher
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] len;
    logic [31:0] wr_addr;
    logic [31:0] rd_addr;
  } dsp_src_t;

  // One CSR access
  typedef struct packed {
    logic [CSR_AW-1:0] addr;
    logic rd;
    logic wr;
    logic [CSR_DW-1:0] wdata;
  } dsp_csr_req_t;

endpackage : dsp_pkg

`default_nettype wire

// ===== dsp_poll_timer.sv
// Purpose: Poll interval countdown for the descriptor prefetcher.
// Assumes: start_i pulses in the cycle read data returns.
// Notes: An interval of zero expires one cycle after start.
`default_nettype none

module dsp_poll_timer (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [dsp_pkg::POLL_W-1:0] interval_i,
  output logic done_o
);

  logic [dsp_pkg::POLL_W-1:0] cnt_reg;
  logic [dsp_pkg::POLL_W-1:0] cnt_next;
  logic armed_reg;
  logic armed_next;
  wire logic zero_w = (cnt_reg == dsp_pkg::POLL_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Count from the data-return cycle; restart wins over expiry
  assign cnt_next = start_i ? interval_i : (zero_w ? cnt_reg : cnt_reg - 16'h0001); // RQ6
  assign armed_next = start_i | armed_reg;
  assign done_o = armed_reg & zero_w; // RQ21

  // Counter and armed flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= dsp_pkg::POLL_RST;
      armed_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      armed_reg <= armed_next;
    end
  end

endmodule : dsp_poll_timer

`default_nettype wire

// ===== dsp_prefetcher.sv
// Purpose: Descriptor prefetcher: fetch, dispatch and write back linked descriptors.
// Assumes: Memory hosts and dispatcher run on clock_i; one descriptor per read beat.
// Notes: CSR slave has zero wait states and one cycle read latency.
//
// Functional notes
// RQ1 - Set-only fields: written one sets, written zero leaves the field alone.
// RQ2 - Polling off: run clears at list end or on an unowned descriptor.
// RQ3 - Polling on: run stays set and fetching continues past list end.
// RQ4 - Run also clears when the soft reset sequence finishes.
// RQ5 - Poll interval is bits 15:0, read-write, reset zero, upper bits zero.
// RQ6 - Poll interval counting starts when fetch read data returns.
// RQ7 - Interrupt status bit 0 sets on each interrupt event, resets to zero.
// RQ8 - Interrupt status clears on written one; written zero does nothing.
// RQ9 - Descriptor read address is 32 bits with extended features off.
// RQ10 - Descriptor read and write data paths have one fixed legal width.
// RQ11 - Burst count output sized by the configured maximum burst.
// RQ12 - Hold request and address during wait request; take data on valid.
// RQ13 - Write byte enable has one bit per data byte.
// RQ14 - CSR has zero wait states and returns read data one cycle later.
// RQ15 - CSR carries 32-bit data with a 3-bit word address.
// RQ16 - Descriptors stream out with valid/ready, zero ready latency.
// RQ17 - Polling on: reread ownership at the interval, resume when owned.
// RQ18 - Control bit 2 starts soft reset; hardware clears it when done.
// RQ19 - Global interrupt enable gates events before the status flag.
// RQ20 - Writing one to run starts descriptor fetching.
// RQ21 - Zero poll interval re-polls right after read data returns.
// RQ22 - Interrupt output follows the interrupt status flag.
`default_nettype none

module dsp_prefetcher (
  input wire logic clock_i,
  input wire logic rst_b_i,
  // CSR slave
  input wire logic [dsp_pkg::CSR_AW-1:0] csr_address_i,
  input wire logic csr_read_i,
  input wire logic csr_write_i,
  input wire logic [dsp_pkg::CSR_DW-1:0] csr_writedata_i,
  output logic [dsp_pkg::CSR_DW-1:0] csr_readdata_o,
  // Descriptor read host
  output logic [dsp_pkg::ADDR_W-1:0] rd_address_o,
  output logic rd_read_o,
  output logic [dsp_pkg::BURST_W-1:0] rd_burstcount_o,
  input wire logic [dsp_pkg::DATA_W-1:0] rd_readdata_i,
  input wire logic rd_waitrequest_i,
  input wire logic rd_readdatavalid_i,
  // Descriptor write-back host
  output logic [dsp_pkg::ADDR_W-1:0] wr_address_o,
  output logic wr_write_o,
  output logic [dsp_pkg::DATA_W-1:0] wr_writedata_o,
  output logic [dsp_pkg::BE_W-1:0] wr_byteenable_o,
  input wire logic wr_waitrequest_i,
  // Descriptor source to the dispatcher
  output logic src_valid_o,
  input wire logic src_ready_i,
  output dsp_pkg::dsp_src_t src_data_o,
  // Interrupt event from the response path, and interrupt line
  input wire logic irq_event_i,
  output logic irq_o
);

  typedef enum logic [2:0] {
    DSP_IDLE,
    DSP_RD_REQ,
    DSP_RD_WAIT,
    DSP_SEND,
    DSP_WR_REQ,
    DSP_POLL
  } dsp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  dsp_pkg::dsp_csr_req_t req_w;
  dsp_state_t state_reg;
  dsp_state_t state_next;
  logic [dsp_pkg::ADDR_W-1:0] ptr_reg;
  logic [dsp_pkg::ADDR_W-1:0] ptr_next;
  logic [dsp_pkg::ADDR_W-1:0] cur_reg;
  logic [dsp_pkg::ADDR_W-1:0] cur_next;
  logic [dsp_pkg::DATA_W-1:0] desc_reg;
  logic [dsp_pkg::DATA_W-1:0] desc_next;
  logic run_reg;
  logic run_next;
  logic poll_en_reg;
  logic poll_en_next;
  logic srst_reg;
  logic srst_next;
  logic gie_reg;
  logic gie_next;
  logic irq_reg;
  logic irq_next;
  logic [dsp_pkg::POLL_W-1:0] poll_reg;
  logic [dsp_pkg::POLL_W-1:0] poll_next;
  logic [dsp_pkg::CSR_DW-1:0] rdata_reg;
  logic [dsp_pkg::CSR_DW-1:0] rdata_next;
  logic hw_clr_run;
  logic srst_done;
  logic poll_done;

  // Field write helper used by every set-only bit
  function automatic logic w1s(input logic cur, input logic hit, input logic bitv);
    w1s = cur | (hit & bitv);
  endfunction : w1s

  ////////////////////////////////////////////////////////////////////////////
  // CSR decode; accesses never stall
  assign req_w = '{addr: csr_address_i, rd: csr_read_i, wr: csr_write_i,
                   wdata: csr_writedata_i}; // RQ15
  wire logic wr_ptr_w = req_w.wr & (req_w.addr == dsp_pkg::OFS_NEXT_PTR);
  wire logic wr_ctl_w = req_w.wr & (req_w.addr == dsp_pkg::OFS_CONTROL);
  wire logic wr_poll_w = req_w.wr & (req_w.addr == dsp_pkg::OFS_POLL);
  wire logic wr_sts_w = req_w.wr & (req_w.addr == dsp_pkg::OFS_STATUS);

  // Incoming descriptor fields
  wire logic own_w = rd_readdata_i[dsp_pkg::D_OWN];
  wire logic [dsp_pkg::ADDR_W-1:0] link_w = desc_reg[dsp_pkg::D_NEXT +: dsp_pkg::ADDR_W];
  wire logic data_in_w = (state_reg == DSP_RD_WAIT) & rd_readdatavalid_i; // RQ12
  wire logic rd_take_w = (state_reg == DSP_RD_REQ) & ~rd_waitrequest_i;
  wire logic wr_take_w = (state_reg == DSP_WR_REQ) & ~wr_waitrequest_i;
  wire logic src_take_w = src_valid_o & src_ready_i; // RQ16

  ////////////////////////////////////////////////////////////////////////////
  // Poll timer, armed by every descriptor read return
  dsp_poll_timer u_poll_timer (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(data_in_w), // RQ6
    .interval_i(poll_reg),
    .done_o(poll_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fetch sequencer. Soft reset only ends where no bus request is open,
  // so an accepted read still gets its data before the engine stops.
  always_comb begin
    state_next = state_reg;
    hw_clr_run = 1'b0;
    srst_done = 1'b0;
    cur_next = cur_reg;
    ptr_next = ptr_reg;
    case (state_reg)
      DSP_IDLE: begin
        if (srst_reg) begin
          srst_done = 1'b1; // RQ18
        end else if (run_reg) begin
          cur_next = ptr_reg; // RQ20
          state_next = DSP_RD_REQ;
        end
      end
      DSP_RD_REQ: begin
        if (rd_take_w) begin
          state_next = DSP_RD_WAIT;
        end
      end
      DSP_RD_WAIT: begin
        if (data_in_w) begin
          if (srst_reg) begin
            state_next = DSP_IDLE;
          end else if (own_w) begin
            state_next = DSP_SEND;
          end else if (poll_en_reg) begin
            state_next = DSP_POLL; // RQ3
          end else begin
            hw_clr_run = 1'b1; // RQ2
            state_next = DSP_IDLE;
          end
        end
      end
      DSP_SEND: begin
        if (srst_reg) begin
          state_next = DSP_IDLE;
        end else if (src_take_w) begin
          state_next = DSP_WR_REQ;
        end
      end
      DSP_WR_REQ: begin
        if (wr_take_w) begin
          ptr_next = link_w;
          cur_next = link_w;
          if (srst_reg) begin
            state_next = DSP_IDLE;
          end else if (run_reg) begin
            state_next = DSP_RD_REQ;
          end else begin
            state_next = DSP_IDLE;
          end
        end
      end
      DSP_POLL: begin
        if (srst_reg) begin
          state_next = DSP_IDLE;
        end else if (poll_done) begin
          state_next = DSP_RD_REQ; // RQ17
        end
      end
      default: begin
        state_next = DSP_IDLE;
      end
    endcase
    if (wr_ptr_w) begin
      ptr_next = req_w.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status next values; software sets beat hardware clears
  assign run_next = w1s(run_reg & ~hw_clr_run & ~srst_done, wr_ctl_w,
                        req_w.wdata[dsp_pkg::CTL_RUN]); // RQ1 RQ4 RQ20
  assign srst_next = w1s(srst_reg & ~srst_done, wr_ctl_w,
                         req_w.wdata[dsp_pkg::CTL_SRST]); // RQ1 RQ18
  assign poll_en_next = wr_ctl_w ? req_w.wdata[dsp_pkg::CTL_POLL_EN] : poll_en_reg;
  assign gie_next = wr_ctl_w ? req_w.wdata[dsp_pkg::CTL_GIE] : gie_reg;
  assign poll_next = wr_poll_w ? req_w.wdata[dsp_pkg::POLL_W-1:0] : poll_reg; // RQ5

  // Event gated before latching; a same-cycle event beats the clear
  assign irq_next = (irq_reg & ~(wr_sts_w & req_w.wdata[dsp_pkg::STS_IRQ]))
                    | (irq_event_i & gie_reg); // RQ7 RQ8 RQ19

  // Captured descriptor goes back to memory with ownership already dropped
  always_comb begin
    desc_next = desc_reg;
    if (data_in_w) begin
      desc_next = rd_readdata_i;
      desc_next[dsp_pkg::D_OWN] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CSR read mux; unmapped words read zero
  wire logic [dsp_pkg::CSR_DW-1:0] ctl_w = {28'h000_0000, gie_reg, srst_reg,
                                            poll_en_reg, run_reg};
  assign rdata_next = !req_w.rd ? rdata_reg :
                      (req_w.addr == dsp_pkg::OFS_NEXT_PTR) ? ptr_reg :
                      (req_w.addr == dsp_pkg::OFS_CONTROL) ? ctl_w :
                      (req_w.addr == dsp_pkg::OFS_POLL) ? {16'h0000, poll_reg} : // RQ5
                      (req_w.addr == dsp_pkg::OFS_STATUS) ? {31'h0000_0000, irq_reg} :
                      32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= DSP_IDLE;
      cur_reg <= dsp_pkg::NEXT_PTR_RST;
      ptr_reg <= dsp_pkg::NEXT_PTR_RST;
      desc_reg <= '0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      ptr_reg <= ptr_next;
      desc_reg <= desc_next;
    end
  end

  // Control bits
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_reg <= 1'b0;
      poll_en_reg <= 1'b0;
      srst_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      poll_en_reg <= poll_en_next;
      srst_reg <= srst_next;
      gie_reg <= gie_next;
    end
  end

  // Interval, interrupt status and read data (one cycle latency)
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      poll_reg <= dsp_pkg::POLL_RST;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      poll_reg <= poll_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next; // RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; addresses stay put while a request is stalled
  assign csr_readdata_o = rdata_reg;
  assign rd_address_o = cur_reg; // RQ9 RQ12
  assign rd_read_o = (state_reg == DSP_RD_REQ); // RQ12
  assign rd_burstcount_o = dsp_pkg::BURST_ONE; // RQ11
  assign wr_address_o = cur_reg; // RQ12
  assign wr_write_o = (state_reg == DSP_WR_REQ);
  assign wr_writedata_o = desc_reg; // RQ10
  assign wr_byteenable_o = {dsp_pkg::BE_W{1'b1}}; // RQ13
  assign src_valid_o = (state_reg == DSP_SEND) & ~srst_reg; // RQ16
  assign src_data_o = '{ctrl: desc_reg[dsp_pkg::D_CTRL +: 32],
                        len: desc_reg[dsp_pkg::D_LEN +: 32],
                        wr_addr: desc_reg[dsp_pkg::D_WR_ADDR +: 32],
                        rd_addr: desc_reg[dsp_pkg::D_RD_ADDR +: 32]};
  assign irq_o = irq_reg; // RQ22

endmodule : dsp_prefetcher

`default_nettype wire

// ===== dsp_prefetcher_monitor.sv
// Purpose: Port-level checks of the descriptor prefetcher.
// Assumes: Mirrors of the RW control fields follow CSR writes.
// Notes: Soft reset may drop src valid early, so the stream hold skips it.
`default_nettype none

module dsp_prefetcher_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [dsp_pkg::CSR_AW-1:0] csr_address_i,
  input wire logic csr_read_i,
  input wire logic csr_write_i,
  input wire logic [dsp_pkg::CSR_DW-1:0] csr_writedata_i,
  input wire logic [dsp_pkg::CSR_DW-1:0] csr_readdata_o,
  input wire logic [dsp_pkg::ADDR_W-1:0] rd_address_o,
  input wire logic rd_read_o,
  input wire logic [dsp_pkg::BURST_W-1:0] rd_burstcount_o,
  input wire logic [dsp_pkg::DATA_W-1:0] rd_readdata_i,
  input wire logic rd_waitrequest_i,
  input wire logic rd_readdatavalid_i,
  input wire logic [dsp_pkg::ADDR_W-1:0] wr_address_o,
  input wire logic wr_write_o,
  input wire logic [dsp_pkg::BE_W-1:0] wr_byteenable_o,
  input wire logic wr_waitrequest_i,
  input wire logic src_valid_o,
  input wire logic src_ready_i,
  input wire dsp_pkg::dsp_src_t src_data_o,
  input wire logic irq_event_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gie_reg;
  logic pen_reg;
  logic [15:0] poll_reg;
  // Decoded CSR events
  wire ctl_wr = csr_write_i && csr_address_i == dsp_pkg::OFS_CONTROL;
  wire srst_wr = ctl_wr && csr_writedata_i[dsp_pkg::CTL_SRST];
  wire sts_clr = csr_write_i && csr_address_i == dsp_pkg::OFS_STATUS && csr_writedata_i[0];
  wire unowned = rd_readdatavalid_i && !rd_readdata_i[dsp_pkg::D_OWN];

  ////////////////////////////////////////////////////////////////////////////
  // Mirrors, so checks need no peek inside the design
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gie_reg <= 1'b0;
      pen_reg <= 1'b0;
      poll_reg <= 16'h0000;
    end else begin
      if (ctl_wr) gie_reg <= csr_writedata_i[dsp_pkg::CTL_GIE];
      if (ctl_wr) pen_reg <= csr_writedata_i[dsp_pkg::CTL_POLL_EN];
      if (csr_write_i && csr_address_i == dsp_pkg::OFS_POLL) poll_reg <= csr_writedata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_irq_set; irq_event_i && gie_reg |=> irq_o; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not set");
  property p_irq_gate; !irq_o && !(irq_event_i && gie_reg) |=> !irq_o; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq set unasked");
  property p_irq_clr; irq_o && sts_clr && !irq_event_i |=> !irq_o; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
  property p_irq_keep; irq_o && !sts_clr |=> irq_o; endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
  property p_poll_rd;
    csr_read_i && !csr_write_i && csr_address_i == dsp_pkg::OFS_POLL
    |=> csr_readdata_o == {16'h0000, poll_reg};
  endproperty
  a_poll_rd: assert property (p_poll_rd) else $error("poll readback wrong");
  property p_rd_hold; rd_read_o && rd_waitrequest_i |=> rd_read_o && $stable(rd_address_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read not held");
  property p_wr_hold; wr_write_o && wr_waitrequest_i |=> wr_write_o && $stable(wr_address_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write not held");
  property p_src_hold;
    src_valid_o && !src_ready_i && !srst_wr && !$past(srst_wr)
    |=> src_valid_o && $stable(src_data_o);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("stream not held");
  property p_fixed; rd_burstcount_o == dsp_pkg::BURST_ONE && &wr_byteenable_o; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed outputs wrong");
  property p_stop; unowned && !pen_reg && !csr_write_i |=> (!rd_read_o && !src_valid_o) [*2];
  endproperty
  a_stop: assert property (p_stop) else $error("fetch kept going");
  property p_repoll; unowned && pen_reg && poll_reg == 16'h0000 |-> ##[1:3] rd_read_o;
  endproperty
  a_repoll: assert property (p_repoll) else $error("no zero interval repoll");
endmodule : dsp_prefetcher_monitor

bind dsp_prefetcher dsp_prefetcher_monitor u_mon (.clock_i, .rst_b_i, .csr_address_i,
  .csr_read_i, .csr_write_i, .csr_writedata_i, .csr_readdata_o, .rd_address_o, .rd_read_o,
  .rd_burstcount_o, .rd_readdata_i, .rd_waitrequest_i, .rd_readdatavalid_i, .wr_address_o,
  .wr_write_o, .wr_byteenable_o, .wr_waitrequest_i, .src_valid_o, .src_ready_i, .src_data_o,
  .irq_event_i, .irq_o);

`default_nettype wire

// ===== dsp_mem_model.sv
// Purpose: Descriptor memory and dispatcher ready for the prefetcher bench.
// Assumes: Eight 32-byte descriptor slots, indexed by address bits 7:5.
// Notes: Slow mode toggles stalls and returns read data three cycles late.
`default_nettype none

module dsp_mem_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic [dsp_pkg::ADDR_W-1:0] rd_address_i,
  input wire logic rd_read_i,
  output logic [dsp_pkg::DATA_W-1:0] rd_readdata_o,
  output logic rd_waitrequest_o,
  output logic rd_readdatavalid_o,
  input wire logic [dsp_pkg::ADDR_W-1:0] wr_address_i,
  input wire logic wr_write_i,
  input wire logic [dsp_pkg::DATA_W-1:0] wr_writedata_i,
  output logic wr_waitrequest_o,
  output logic src_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [dsp_pkg::DATA_W-1:0] mem [8];
  logic [1:0] lat_reg;
  logic [dsp_pkg::ADDR_W-1:0] raddr_reg;
  initial rd_readdata_o = '0;
  // Take requests at the edge where stall is low; one read outstanding
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat_reg <= 2'h0;
    end else begin
      if (wr_write_i && !wr_waitrequest_o) mem[wr_address_i[7:5]] <= wr_writedata_i;
      if (rd_read_i && !rd_waitrequest_o) begin
        raddr_reg <= rd_address_i;
        lat_reg <= slow_i ? 2'h3 : 2'h1;
      end else if (lat_reg != 2'h0) begin
        lat_reg <= lat_reg - 2'h1;
      end
    end
  end
  // Idle data inverts each cycle so a stale beat never passes for a fresh one
  always @(negedge clock_i) begin
    rd_readdatavalid_o <= lat_reg == 2'h1;
    rd_readdata_o <= (lat_reg == 2'h1) ? mem[raddr_reg[7:5]] : ~rd_readdata_o;
    rd_waitrequest_o <= slow_i && !rd_waitrequest_o;
    wr_waitrequest_o <= slow_i && !wr_waitrequest_o;
    src_ready_o <= !slow_i || !src_ready_o;
  end
endmodule : dsp_mem_model

`default_nettype wire

// ===== dsp_prefetcher_tb_top.sv
// Purpose: Self-checking bench of the descriptor prefetcher.
// Assumes: Inputs change at the falling edge; memory model answers.
// Notes: Poll gaps allow two cycles of pipeline slack.
`default_nettype none

module dsp_prefetcher_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rst_b_i = 1'b0, csr_read_i = 1'b0, csr_write_i = 1'b0;
  logic irq_event_i = 1'b0, slow = 1'b0;
  logic [2:0] csr_address_i = 3'h0;
  logic [31:0] csr_writedata_i = 32'h0, csr_readdata_o, rd_address_o, wr_address_o;
  logic rd_read_o, rd_waitrequest_i, rd_readdatavalid_i, wr_write_o, wr_waitrequest_i;
  logic src_valid_o, src_ready_i, irq_o;
  logic [0:0] rd_burstcount_o;
  logic [255:0] rd_readdata_i, wr_writedata_o;
  logic [31:0] wr_byteenable_o;
  dsp_pkg::dsp_src_t src_data_o;
  dsp_pkg::dsp_src_t got_q[$];
  int n_errors = 0, check_count = 0;

  dsp_prefetcher u_dut (.clock_i, .rst_b_i, .csr_address_i, .csr_read_i, .csr_write_i,
    .csr_writedata_i, .csr_readdata_o, .rd_address_o, .rd_read_o, .rd_burstcount_o,
    .rd_readdata_i, .rd_waitrequest_i, .rd_readdatavalid_i, .wr_address_o, .wr_write_o,
    .wr_writedata_o, .wr_byteenable_o, .wr_waitrequest_i, .src_valid_o, .src_ready_i,
    .src_data_o, .irq_event_i, .irq_o);
  dsp_mem_model u_mem (.clock_i(clock_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .rd_address_i(rd_address_o), .rd_read_i(rd_read_o), .rd_readdata_o(rd_readdata_i),
    .rd_waitrequest_o(rd_waitrequest_i), .rd_readdatavalid_o(rd_readdatavalid_i),
    .wr_address_i(wr_address_o), .wr_write_i(wr_write_o), .wr_writedata_i(wr_writedata_o),
    .wr_waitrequest_o(wr_waitrequest_i), .src_ready_o(src_ready_i));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and stream capture
  initial forever #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (src_valid_o && src_ready_i) got_q.push_back(src_data_o);

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic csr_wr(input logic [2:0] a, input logic [31:0] d);
    @(negedge clock_i) {csr_address_i, csr_writedata_i, csr_write_i} = {a, d, 1'b1};
    @(negedge clock_i) csr_write_i = 1'b0;
  endtask : csr_wr
  task automatic csr_rd(input logic [2:0] a, output logic [31:0] d);
    @(negedge clock_i) {csr_address_i, csr_read_i} = {a, 1'b1};
    @(negedge clock_i) csr_read_i = 1'b0;
    d = csr_readdata_o;
  endtask : csr_rd
  // Descriptor: own bit 254, next pointer in 127:96, tag marks each field
  function automatic logic [255:0] desc(input logic own, input logic [2:0] nx, input logic [7:0] t);
    desc = {1'b0, own, 22'h0, t, 96'h0, 24'h0, nx, 5'h00, 24'h0, t, 24'h0, ~t, 24'h0, t};
  endfunction : desc
  function automatic logic [127:0] sent(input logic [255:0] d);
    sent = {d[255:224], d[95:64], d[63:32], d[31:0]};
  endfunction : sent
  task automatic wait_idle;
    logic [31:0] v;
    v = 32'h1;
    repeat (300) if (v[0] || v[2]) csr_rd(dsp_pkg::OFS_CONTROL, v);
    chk(v & 32'h5, 0);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    logic [31:0] v;
    csr_rd(dsp_pkg::OFS_POLL, v);
    chk(v, 0);
    csr_rd(dsp_pkg::OFS_STATUS, v);
    chk(v, 0);
    csr_wr(dsp_pkg::OFS_POLL, 32'hffff_abcd);
    csr_rd(dsp_pkg::OFS_POLL, v);
    chk(v, 32'h0000_abcd);
    csr_rd(3'h5, v);
    chk(v, 0);
  endtask : t_regs
  task automatic t_list;
    slow = 1'b1;
    u_mem.mem[0] = desc(1, 1, 8'h11);
    u_mem.mem[1] = desc(1, 2, 8'h22);
    u_mem.mem[2] = desc(0, 3, 8'h33);
    csr_wr(dsp_pkg::OFS_NEXT_PTR, 32'h0);
    csr_wr(dsp_pkg::OFS_CONTROL, 32'h1);
    csr_wr(dsp_pkg::OFS_CONTROL, 32'h0);
    wait_idle();
    chk(got_q.size(), 2);
    // Streamed copy comes from the held word, ownership already dropped
    chk(got_q[0], sent(desc(0, 1, 8'h11)));
    chk(got_q[1], sent(desc(0, 2, 8'h22)));
    chk(u_mem.mem[0][254], 0);
    got_q.delete();
    slow = 1'b0;
  endtask : t_list
  task automatic t_poll;
    logic [31:0] v;
    int n;
    u_mem.mem[0] = desc(1, 1, 8'h44);
    u_mem.mem[1] = desc(0, 2, 8'h00);
    // Interval cleared from the register test's long value, pointer set back to the list head
    csr_wr(dsp_pkg::OFS_POLL, 32'h0);
    csr_wr(dsp_pkg::OFS_NEXT_PTR, 32'h0);
    csr_wr(dsp_pkg::OFS_CONTROL, 32'h3);
    for (int i = 0; i < 2; i++) begin
      n = (i == 0) ? 0 : 5;
      csr_wr(dsp_pkg::OFS_POLL, n);
      // Look one edge later, so the beat caught was timed with the new interval
      repeat (100) begin
        @(posedge clock_i) #1;
        if (rd_readdatavalid_i && !rd_readdata_i[254]) break;
      end
      v = 0;
      while (!rd_read_o && v < 100) @(posedge clock_i) #1 v++;
      chk(v >= n && v <= n + 2, 1);
    end
    csr_rd(dsp_pkg::OFS_CONTROL, v);
    chk(v[0], 1);
    u_mem.mem[2] = desc(0, 3, 8'h00);
    u_mem.mem[1] = desc(1, 2, 8'h55);
    repeat (200) if (got_q.size() < 2) @(negedge clock_i);
    chk(got_q.size() == 2 ? got_q[1] : 0, sent(desc(0, 2, 8'h55)));
    csr_wr(dsp_pkg::OFS_CONTROL, 32'h6);
    wait_idle();
  endtask : t_poll
  task automatic t_irq;
    logic [31:0] v;
    for (int g = 0; g < 2; g++) begin
      csr_wr(dsp_pkg::OFS_CONTROL, g ? 32'h8 : 32'h0);
      @(negedge clock_i) irq_event_i = 1'b1;
      @(negedge clock_i) irq_event_i = 1'b0;
      csr_rd(dsp_pkg::OFS_STATUS, v);
      chk(v, g);
      chk(irq_o, g);
    end
    csr_wr(dsp_pkg::OFS_STATUS, 32'h0);
    csr_rd(dsp_pkg::OFS_STATUS, v);
    chk(v, 1);
    csr_wr(dsp_pkg::OFS_STATUS, 32'h1);
    csr_rd(dsp_pkg::OFS_STATUS, v);
    chk({v, irq_o}, 0);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Run is a few hundred cycles; the watchdog allows ten thousand
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    @(negedge clock_i) rst_b_i = 1'b1;
    t_regs();
    t_list();
    t_poll();
    t_irq();
    conclude();
  end
endmodule : dsp_prefetcher_tb_top

`default_nettype wire
